// *** common/dmau_pkg.sv ***
// Constants shared by the data memory addressing unit and its bench.
// Assumes a 40 MHz core clock and an APB register port with 32-bit data.
package dmau_pkg;

    // Data memory addresses of the unit's own registers; also APB word indices, except the control register at 40H.
    localparam logic [7:0] ADDR_INDIRECT_PORT_ZERO = 8'h00;
    localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
    localparam logic [7:0] ADDR_INDIRECT_PORT_ONE = 8'h02;
    localparam logic [7:0] ADDR_POINTER_ONE = 8'h03;
    localparam logic [7:0] ADDR_BANK_SELECTOR = 8'h04;
    localparam logic [7:0] ADDR_WORKING_REGISTER = 8'h05;
    localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW = 8'h06;
    localparam logic [7:0] ADDR_NONVOLATILE_CONTROL = 8'h40;

    // Registers of my own beyond the core map, as APB word indices.
    localparam logic [7:0] IDX_ACCESS_ADDR = 8'h08;
    localparam logic [7:0] IDX_ACCESS_CTRL = 8'h09;
    localparam logic [7:0] IDX_ACCESS_DATA = 8'h0A;
    localparam logic [7:0] IDX_STATUS = 8'h0B;
    localparam logic [7:0] IDX_PROGRAM_COUNTER = 8'h0C;

    // Access control bit positions.
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_ALU_BIT = 2;

    // Special function area ends here; general memory above up to RAM size.
    localparam logic [7:0] SFR_LAST = 8'h3F;
    localparam logic [7:0] RAM_LAST = 8'h7F;
    localparam int RAM_WORDS = 64;

    // Reset values.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [11:0] RESET_PC = 12'h000;
    localparam logic POINTER_TOP_ONE = 1'b1;
    localparam int DUMMY_CYCLES = 1;

    // Core access sequencing states, one-hot.
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DUMMY = 3'b100
    } dmau_state_type;

endpackage

// *** rtl/dmau_core.sv ***
// Data memory addressing unit: pointers, bank selector, working register,
// program counter low byte, a 64-byte general RAM bank and the bank 1 control
// register, reached by software over APB and by a core-side access port.
// Assumes one 40 MHz clock, synchronous active-high reset, synchronous inputs.
//
// Overview of operation
// - Indirect port accesses go to the address held in the matching pointer.
// - Pointer zero reaches bank 0 only; pointer one reaches either bank.
// - A pointer naming an indirect port reads 00H and ignores writes.
// - Both pointers are real read/write storage supplying the effective address.
// - On small RAM variants pointer bit 7 has no storage and reads one.
// - Bank selector 00 picks bank 0, 01 picks bank 1.
// - Pointer zero accesses land in bank 0 whatever the bank selector holds.
// - The nonvolatile control register at 40H bank 1 needs pointer one and bank selector bit 0 set.
// - Resets clear bank selection except a watchdog reset during power down.
// - Special function registers answer identically in both banks.
// - Direct addresses always resolve into bank 0.
// - The working register receives every ALU result.
// - No operation moves one data register straight to another.
// - Writing program counter low byte jumps within the current page.
// - A program counter low byte write inserts one dummy cycle.
// - Unused locations, including reserved special addresses, read 00H.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module dmau_core
    import dmau_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic wdt_pd_reset_i,
    input wire logic [7:0] alu_result_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [7:0] nonvolatile_control_o,
    output logic [11:0] program_counter_o,
    output logic dummy_cycle_o,
    output logic [7:0] bank_selector_o
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.

    logic [7:0] pointer_zero_ff;
    logic [6:0] pointer_zero_low_ff;
    logic [7:0] pointer_one_ff;
    logic [6:0] pointer_one_low_ff;
    logic [7:0] bank_selector_ff;
    logic [7:0] working_register_ff;
    logic [11:0] program_counter_ff;
    logic [7:0] nonvolatile_control_ff;
    logic [7:0] access_addr_ff;
    logic access_write_ff;
    logic access_alu_ff;
    logic [7:0] access_data_ff;
    logic [7:0] access_result_ff;
    logic busy_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic dummy_ff;
    dmau_state_type state_ff;
    dmau_state_type nxt_state;
    logic [7:0] ram_ff [RAM_WORDS];

    ////////////////////////////////////////////////////////////////////////
    // Effective address resolution for a core access, purely combinational.

    logic via_port_zero;
    logic via_port_one;
    logic [7:0] eff_addr;
    logic eff_bank_one;
    logic eff_is_port;
    logic eff_is_sfr;
    logic eff_is_ram;
    logic eff_is_nvc;
    logic [7:0] eff_rdata;
    logic [7:0] sfr_rdata;
    logic [7:0] wr_value;
    logic core_wr;

    // Pointer reads show bit 7 as one because it has no storage.
    assign pointer_zero_ff = {POINTER_TOP_ONE, pointer_zero_low_ff};
    assign pointer_one_ff = {POINTER_TOP_ONE, pointer_one_low_ff};

    assign via_port_zero = (access_addr_ff == ADDR_INDIRECT_PORT_ZERO);
    assign via_port_one = (access_addr_ff == ADDR_INDIRECT_PORT_ONE);
    // Indirect ports redirect to their pointer; the unstored top bit is zero here.
    assign eff_addr = via_port_zero ? {1'b0, pointer_zero_low_ff}
        : via_port_one ? {1'b0, pointer_one_low_ff} : access_addr_ff;
    // Only pointer one honours the bank selector, and only its low bit.
    assign eff_bank_one = via_port_one & bank_selector_ff[0];
    assign eff_is_port = (eff_addr == ADDR_INDIRECT_PORT_ZERO)
        | (eff_addr == ADDR_INDIRECT_PORT_ONE);
    // The special area is bank-independent.
    assign eff_is_sfr = (eff_addr <= SFR_LAST) & ~eff_is_port;
    assign eff_is_ram = (eff_addr > SFR_LAST) & (eff_addr <= RAM_LAST) & ~eff_bank_one;
    assign eff_is_nvc = eff_bank_one & (eff_addr == ADDR_NONVOLATILE_CONTROL);

    // Special register read mux; all other special addresses read zero.
    assign sfr_rdata = (eff_addr == ADDR_POINTER_ZERO) ? pointer_zero_ff
        : (eff_addr == ADDR_POINTER_ONE) ? pointer_one_ff
        : (eff_addr == ADDR_BANK_SELECTOR) ? bank_selector_ff
        : (eff_addr == ADDR_WORKING_REGISTER) ? working_register_ff
        : (eff_addr == ADDR_PROGRAM_COUNTER_LOW) ? program_counter_ff[7:0]
        : RESET_BYTE;

    assign eff_rdata = eff_is_sfr ? sfr_rdata
        : eff_is_ram ? ram_ff[eff_addr[5:0]]
        : eff_is_nvc ? nonvolatile_control_ff
        : RESET_BYTE;

    // A core write stores the supplied byte, or the ALU result when flagged.
    assign wr_value = access_alu_ff ? alu_result_i : access_data_ff;
    assign core_wr = (state_ff == ST_EXEC) & access_write_ff;

    ////////////////////////////////////////////////////////////////////////
    // APB decode. Byte address is four times the word index.

    logic apb_setup;
    logic apb_wr;
    logic [7:0] apb_idx;
    logic apb_aligned;
    logic apb_map_reg;
    logic apb_map_own;
    logic apb_hit;
    logic [31:0] apb_rdata;
    logic apb_go;
    logic apb_pc_low_wr;
    logic core_pc_low_wr;

    assign apb_setup = psel_i & ~penable_i;
    assign apb_idx = paddr_i[9:2];
    assign apb_aligned = (paddr_i[1:0] == 2'b00) & (paddr_i[11:10] == 2'b00);
    assign apb_map_reg = (apb_idx <= ADDR_PROGRAM_COUNTER_LOW);
    assign apb_map_own = (apb_idx >= IDX_ACCESS_ADDR) & (apb_idx <= IDX_PROGRAM_COUNTER);
    assign apb_hit = apb_aligned & (apb_map_reg | apb_map_own);
    assign apb_wr = psel_i & penable_i & pready_ff & pwrite_i & apb_hit; // Access edge only.
    assign apb_go = apb_wr & (apb_idx == IDX_ACCESS_CTRL) & pwdata_i[CTRL_GO_BIT] & ~busy_ff;
    assign apb_pc_low_wr = apb_wr & (apb_idx == ADDR_PROGRAM_COUNTER_LOW);
    assign core_pc_low_wr = core_wr & eff_is_sfr & (eff_addr == ADDR_PROGRAM_COUNTER_LOW);

    // Software sees the core map directly; indirect ports read zero here.
    assign apb_rdata = (apb_idx == ADDR_POINTER_ZERO) ? {24'h0, pointer_zero_ff}
        : (apb_idx == ADDR_POINTER_ONE) ? {24'h0, pointer_one_ff}
        : (apb_idx == ADDR_BANK_SELECTOR) ? {24'h0, bank_selector_ff}
        : (apb_idx == ADDR_WORKING_REGISTER) ? {24'h0, working_register_ff}
        : (apb_idx == ADDR_PROGRAM_COUNTER_LOW) ? {24'h0, program_counter_ff[7:0]}
        : (apb_idx == IDX_ACCESS_ADDR) ? {24'h0, access_addr_ff}
        : (apb_idx == IDX_ACCESS_CTRL) ? {29'h0, access_alu_ff, access_write_ff, busy_ff}
        : (apb_idx == IDX_ACCESS_DATA) ? {24'h0, access_data_ff}
        : (apb_idx == IDX_STATUS) ? {24'h0, access_result_ff}
        : (apb_idx == IDX_PROGRAM_COUNTER) ? {20'h0, program_counter_ff}
        : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer: one execute cycle, plus a dummy after a jump.

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (apb_go)
                begin
                    nxt_state = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                nxt_state = core_pc_low_wr ? ST_DUMMY : ST_IDLE;
            end
            ST_DUMMY:
            begin
                nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State and sequencing flags.
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
            dummy_ff <= 1'b0;
        end
        else if (clk_en_i)
        begin
            state_ff <= nxt_state;
            busy_ff <= (nxt_state != ST_IDLE);
            dummy_ff <= (nxt_state == ST_DUMMY) | apb_pc_low_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointers and bank selector. A core write to an indirect port address
    // lands nowhere, which is how a pointer naming a port ignores writes.

    logic wr_sfr;
    assign wr_sfr = core_wr & eff_is_sfr;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            pointer_zero_low_ff <= 7'h00;
            pointer_one_low_ff <= 7'h00;
            if (!wdt_pd_reset_i)
            begin
                bank_selector_ff <= RESET_BYTE;
            end
        end
        else if (clk_en_i)
        begin
            if (apb_wr && apb_idx == ADDR_POINTER_ZERO)
            begin
                pointer_zero_low_ff <= pwdata_i[6:0];
            end
            else if (wr_sfr && eff_addr == ADDR_POINTER_ZERO)
            begin
                pointer_zero_low_ff <= wr_value[6:0];
            end
            if (apb_wr && apb_idx == ADDR_POINTER_ONE)
            begin
                pointer_one_low_ff <= pwdata_i[6:0];
            end
            else if (wr_sfr && eff_addr == ADDR_POINTER_ONE)
            begin
                pointer_one_low_ff <= wr_value[6:0];
            end
            if (apb_wr && apb_idx == ADDR_BANK_SELECTOR)
            begin
                bank_selector_ff <= pwdata_i[7:0];
            end
            else if (wr_sfr && eff_addr == ADDR_BANK_SELECTOR)
            begin
                bank_selector_ff <= wr_value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working register: ALU results always land here; a move between two
    // data registers needs a read into it and a separate write out of it.

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            working_register_ff <= RESET_BYTE;
        end
        else if (clk_en_i)
        begin
            if (state_ff == ST_EXEC && access_alu_ff)
            begin
                working_register_ff <= alu_result_i;
            end
            else if (state_ff == ST_EXEC && !access_write_ff)
            begin
                working_register_ff <= eff_rdata;
            end
            else if (wr_sfr && eff_addr == ADDR_WORKING_REGISTER)
            begin
                working_register_ff <= wr_value;
            end
            else if (apb_wr && apb_idx == ADDR_WORKING_REGISTER)
            begin
                working_register_ff <= pwdata_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter: a low-byte write keeps the page bits. The counter does
    // not advance on its own; the fetch logic lives elsewhere.

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            program_counter_ff <= RESET_PC;
        end
        else if (clk_en_i)
        begin
            if (core_pc_low_wr)
            begin
                program_counter_ff[7:0] <= wr_value;
            end
            else if (apb_pc_low_wr)
            begin
                program_counter_ff[7:0] <= pwdata_i[7:0];
            end
            else if (apb_wr && apb_idx == IDX_PROGRAM_COUNTER)
            begin
                program_counter_ff <= pwdata_i[11:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access request registers and result capture.

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            access_addr_ff <= RESET_BYTE;
            access_write_ff <= 1'b0;
            access_alu_ff <= 1'b0;
            access_data_ff <= RESET_BYTE;
            access_result_ff <= RESET_BYTE;
        end
        else if (clk_en_i)
        begin
            if (apb_wr && apb_idx == IDX_ACCESS_ADDR && !busy_ff)
            begin
                access_addr_ff <= pwdata_i[7:0];
            end
            if (apb_wr && apb_idx == IDX_ACCESS_DATA && !busy_ff)
            begin
                access_data_ff <= pwdata_i[7:0];
            end
            if (apb_go)
            begin
                access_write_ff <= pwdata_i[CTRL_WRITE_BIT];
                access_alu_ff <= pwdata_i[CTRL_ALU_BIT];
            end
            if (state_ff == ST_EXEC)
            begin
                access_result_ff <= access_write_ff ? wr_value : eff_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // General RAM bank 0 and the bank 1 control register.

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            nonvolatile_control_ff <= RESET_BYTE;
        end
        else if (clk_en_i)
        begin
            if (core_wr && eff_is_nvc)
            begin
                nonvolatile_control_ff <= wr_value;
            end
            if (core_wr && eff_is_ram)
            begin
                ram_ff[eff_addr[5:0]] <= wr_value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: ready one cycle after setup, error on unmapped addresses.

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup & ~apb_hit;
            prdata_ff <= (apb_setup && !pwrite_i && apb_hit) ? apb_rdata : 32'h0000_0000;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign nonvolatile_control_o = nonvolatile_control_ff;
    assign program_counter_o = program_counter_ff;
    assign dummy_cycle_o = dummy_ff;
    assign bank_selector_o = bank_selector_ff;

endmodule

// *** test/dmau_asserts.sv ***
// Port checker for the data memory addressing unit.
// Assumes one clock, synchronous active-high reset, bound onto dmau_core.
`timescale 1ns/1ps
module dmau_asserts
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic wdt_pd_reset_i,
    input wire logic [7:0] alu_result_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [7:0] nonvolatile_control_o,
    input wire logic [11:0] program_counter_o,
    input wire logic dummy_cycle_o,
    input wire logic [7:0] bank_selector_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    ////////////////////////////////////////////////////////////////
    // Decodes of the request taken at a setup edge or, for writes, at the access edge.
    wire logic setup = psel_i && !penable_i && clk_en_i;
    // Writes land at the access edge, where pready is seen high.
    wire logic wr_access = psel_i && penable_i && pready_o && pwrite_i && clk_en_i;
    wire logic ptr_rd = setup && !pwrite_i && (paddr_i == 12'h004 || paddr_i == 12'h00C);
    wire logic port_rd = setup && !pwrite_i && (paddr_i == 12'h000 || paddr_i == 12'h008);
    wire logic pcl_wr = wr_access && paddr_i == 12'h018;
    wire logic [3:0] pc_high = program_counter_o[11:8];
    wire logic [7:0] wdata_low = pwdata_i[7:0];
    wire logic bank_bit = bank_selector_o[0];
    ////////////////////////////////////////////////////////////////
    // The answer comes one cycle after setup, and only then.
    chk_ready_next: assert property (disable iff (sys_rst_i) setup |=> pready_o)
        else $error("pready missing after setup");
    chk_ready_cause: assert property (disable iff (sys_rst_i) pready_o |-> $past(setup))
        else $error("pready without setup");
    chk_err_zero: assert property (disable iff (sys_rst_i) pslverr_o |-> prdata_o == 32'h0)
        else $error("refused read not zero");
    chk_ptr_top: assert property (disable iff (sys_rst_i) $past(ptr_rd) |-> prdata_o[7])
        else $error("pointer top bit not one");
    chk_port_zero: assert property (disable iff (sys_rst_i) $past(port_rd) |-> prdata_o == 32'h0)
        else $error("indirect port read not zero");
    chk_jump_low: assert property (disable iff (sys_rst_i)
        pcl_wr |=> program_counter_o == {$past(pc_high), $past(wdata_low)})
        else $error("low byte jump wrong");
    chk_dummy_follow: assert property (disable iff (sys_rst_i) pcl_wr |=> ##[0:1] dummy_cycle_o)
        else $error("dummy cycle missing");
    chk_dummy_pulse: assert property (disable iff (sys_rst_i) dummy_cycle_o |=> !dummy_cycle_o)
        else $error("dummy cycle too long");
    chk_bank_write: assert property (disable iff (sys_rst_i)
        wr_access && paddr_i == 12'h010 |=> bank_selector_o == $past(wdata_low))
        else $error("bank selector write lost");
    // Reset behaviour itself is under test, so these two are not disabled by it.
    chk_bank_reset: assert property (sys_rst_i && !wdt_pd_reset_i && clk_en_i
        |=> bank_selector_o == 8'h00)
        else $error("bank selector not cleared");
    chk_bank_keep: assert property (sys_rst_i && wdt_pd_reset_i && clk_en_i
        |=> $stable(bank_selector_o))
        else $error("bank selector lost in watchdog reset");
    chk_nvc_bank: assert property (disable iff (sys_rst_i)
        $changed(nonvolatile_control_o) |-> $past(bank_bit))
        else $error("control register reached from bank 0");
    cov_refused: cover property (pready_o && pslverr_o);
    cov_dummy: cover property (dummy_cycle_o);
    cov_nvc: cover property (disable iff (sys_rst_i) $changed(nonvolatile_control_o));
endmodule

bind dmau_core dmau_asserts dmau_asserts_inst (.*);

// *** test/dmau_exec_model.sv ***
// APB master standing in for the core's instruction execution logic.
// Assumes the slave answers with pready; a hang is cut by the bench timeout.
`timescale 1ns/1ps
module dmau_exec_model
(
    input wire logic clk_sys_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o = 1'b0,
    output logic penable_o = 1'b0,
    output logic pwrite_o = 1'b0,
    output logic [11:0] paddr_o = 12'h000,
    output logic [31:0] pwdata_o = 32'h0
);
    // One transfer; a leading edge keeps two calls from driving in one step.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk_sys_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_sys_i);
        penable_o <= 1'b1;
        // The answer is taken at the rising edge that sees pready high.
        do @(posedge clk_sys_i); while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released lines show the inverse so stale values never look valid.
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule

// *** test/test_dmau_core.sv ***
// Self-checking bench for the data memory addressing unit.
// Assumes dmau_core, its checker and the APB model are compiled beforehand.
`timescale 1ns/1ps
module test_dmau_core
    import dmau_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic wdt_pd_reset_i = 1'b0;
    logic [7:0] alu_result_i = 8'h00;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, dummy_cycle_o;
    logic [11:0] paddr_i, program_counter_o;
    logic [31:0] pwdata_i, prdata_o, r;
    logic [7:0] nonvolatile_control_o, bank_selector_o;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    dmau_core dmau_core_inst (.clk_sys_i, .sys_rst_i, .clk_en_i, .wdt_pd_reset_i,
        .alu_result_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .nonvolatile_control_o, .program_counter_o,
        .dummy_cycle_o, .bank_selector_o);
    dmau_exec_model dmau_exec_model_inst (.clk_sys_i, .pready_i(pready_o),
        .pslverr_i(pslverr_o), .prdata_i(prdata_o), .psel_o(psel_i),
        .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
    ////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling well above the few hundred the run needs.
    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Bus helpers; byte address is four times the register index.
    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic e;
        dmau_exec_model_inst.xfer(1'b1, ba(i), {24'h0, d}, r, e);
    endtask
    task automatic rd(input logic [7:0] i, output logic [31:0] q);
        logic e;
        dmau_exec_model_inst.xfer(1'b0, ba(i), 32'h0, q, e);
    endtask
    // One core access, polled until busy clears under a bounded count.
    task automatic core(input logic w, input logic alu, input logic [7:0] a,
        input logic [7:0] d, output logic [31:0] q);
        int k;
        wr(IDX_ACCESS_ADDR, a);
        wr(IDX_ACCESS_DATA, d);
        wr(IDX_ACCESS_CTRL, {5'h0, alu, w, 1'b1});
        k = 0;
        q = 32'h1;
        while (q[CTRL_GO_BIT] !== 1'b0 && k < 20)
        begin
            rd(IDX_ACCESS_CTRL, q);
            k++;
        end
        rd(IDX_STATUS, q);
    endtask
    task automatic do_reset(input logic keep);
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        wdt_pd_reset_i <= keep;
        repeat (5) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        wdt_pd_reset_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset_map();
        logic e;
        rd(ADDR_BANK_SELECTOR, r);
        check(r, 32'h0);
        rd(ADDR_POINTER_ONE, r);
        check(r, 32'h80);
        wr(ADDR_POINTER_ZERO, 8'h45);
        rd(ADDR_POINTER_ZERO, r);
        check(r, 32'hC5);
        rd(ADDR_INDIRECT_PORT_ZERO, r);
        check(r, 32'h0);
        dmau_exec_model_inst.xfer(1'b0, 12'h0C0, 32'h0, r, e);
        check({r[30:0], e}, 32'h1);
    endtask
    task automatic t_ptr0();
        wr(ADDR_BANK_SELECTOR, 8'h01);
        wr(ADDR_POINTER_ZERO, ADDR_NONVOLATILE_CONTROL);
        core(1'b1, 1'b0, ADDR_INDIRECT_PORT_ZERO, 8'h5A, r);
        check({24'h0, nonvolatile_control_o}, 32'h0);
        core(1'b0, 1'b0, 8'h40, 8'h00, r);
        check(r[7:0], 8'h5A);
        rd(ADDR_WORKING_REGISTER, r);
        check(r, 32'h5A);
    endtask
    task automatic t_ptr1();
        wr(ADDR_POINTER_ONE, ADDR_NONVOLATILE_CONTROL);
        core(1'b1, 1'b0, ADDR_INDIRECT_PORT_ONE, 8'h3C, r);
        check({24'h0, nonvolatile_control_o}, 32'h3C);
        wr(ADDR_BANK_SELECTOR, 8'h03);
        core(1'b0, 1'b0, ADDR_INDIRECT_PORT_ONE, 8'h00, r);
        check(r[7:0], 8'h3C);
        core(1'b1, 1'b0, 8'h40, 8'h11, r);
        check({24'h0, nonvolatile_control_o}, 32'h3C);
        wr(ADDR_BANK_SELECTOR, 8'h00);
        core(1'b0, 1'b0, ADDR_INDIRECT_PORT_ONE, 8'h00, r);
        check(r[7:0], 8'h11);
    endtask
    task automatic t_self_sfr();
        wr(ADDR_POINTER_ZERO, ADDR_INDIRECT_PORT_ONE);
        core(1'b1, 1'b0, ADDR_INDIRECT_PORT_ZERO, 8'h77, r);
        core(1'b0, 1'b0, ADDR_INDIRECT_PORT_ZERO, 8'h00, r);
        check(r[7:0], 8'h00);
        core(1'b0, 1'b0, 8'h30, 8'h00, r);
        check(r[7:0], 8'h00);
        wr(ADDR_BANK_SELECTOR, 8'h01);
        wr(ADDR_POINTER_ONE, ADDR_WORKING_REGISTER);
        wr(ADDR_WORKING_REGISTER, 8'h66);
        core(1'b0, 1'b0, ADDR_INDIRECT_PORT_ONE, 8'h00, r);
        check(r[7:0], 8'h66);
    endtask
    task automatic t_alu_pc();
        alu_result_i <= 8'h9D;
        core(1'b1, 1'b1, 8'h41, 8'h00, r);
        rd(ADDR_WORKING_REGISTER, r);
        check(r, 32'h9D);
        core(1'b0, 1'b0, 8'h41, 8'h00, r);
        check(r[7:0], 8'h9D);
        wr(ADDR_PROGRAM_COUNTER_LOW, 8'hAB);
        @(negedge clk_sys_i);
        check({20'h0, program_counter_o}, 32'h0AB);
        check({31'h0, dummy_cycle_o}, 32'h1);
        core(1'b1, 1'b0, ADDR_PROGRAM_COUNTER_LOW, 8'h12, r);
        check({20'h0, program_counter_o}, 32'h012);
    endtask
    task automatic t_wdt();
        wr(ADDR_BANK_SELECTOR, 8'h01);
        do_reset(1'b1);
        check({24'h0, bank_selector_o}, 32'h1);
        do_reset(1'b0);
        check({24'h0, bank_selector_o}, 32'h0);
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_reset_map();
        t_ptr0();
        t_ptr1();
        t_self_sfr();
        t_alu_pc();
        t_wdt();
        complete_run();
    end
endmodule
